// ---- rtl/gsr_coulomb.sv ----
// Current estimate from cell minus open-circuit voltage over internal impedance, and coulomb count.
`timescale 1ns/1ps
`default_nettype none

module gsr_coulomb import gsr_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_srst,
    gsr_est_if.est est
);

    // Internal impedance in milliohms, indexed by the energy level band.
    localparam logic [15:0] RINT_TABLE [0:7] = '{16'h00b4, 16'h00a0, 16'h008c, 16'h0078,
                                                16'h0064, 16'h005a, 16'h0050, 16'h0050};
    localparam int TW = $clog2(TICK_CYCLES);

    logic [TW-1:0] tick_cnt, next_tick_cnt;
    logic signed [15:0] current, next_current;
    logic [15:0] remaining, next_remaining;
    logic signed [31:0] residue, next_residue;
    logic signed [31:0] quot;
    logic [15:0] rint;
    logic tick;

    // Remaining charge in tenths of mAh from full capacity and energy level.
    function automatic logic [15:0] level_capacity(input logic [15:0] fcc, input logic [15:0] lvl);
        logic [31:0] prod;
        prod = 32'(fcc) * 32'(lvl) / 32'(ENERGY_FULL);
        return prod[15:0];
    endfunction : level_capacity

    // Next-state logic for the estimate, the tick timer and the charge count.
    always_comb begin
        rint = RINT_TABLE[3'(est.energy_level >> ENERGY_INDEX_SHIFT)];
        quot = ((32'(signed'({1'b0, est.cell_mv})) - 32'(signed'({1'b0, est.ocv_mv})))
                * MV_PER_MOHM_TO_MA) / signed'(32'(rint));
        tick = (tick_cnt == TW'(TICK_CYCLES - 1));
        next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
        next_current = current;
        if (est.cell_strobe) begin
            if (quot > 32'sd32767) begin
                next_current = 16'sh7fff;
            end else if (quot < -32'sd32768) begin
                next_current = 16'sh8000;
            end else begin
                next_current = quot[15:0];
            end
        end
        next_residue = residue;
        next_remaining = remaining;
        if (est.capacity_load) begin
            next_remaining = level_capacity(est.full_capacity, est.energy_level);
            next_residue = '0;
        end else if (tick) begin
            next_residue = residue + 32'(current);
            if (next_residue >= CHARGE_UNITS) begin
                next_residue = next_residue - CHARGE_UNITS;
                if (remaining != 16'hffff) next_remaining = remaining + HEALTH_STEP;
            end else if (next_residue <= -CHARGE_UNITS) begin
                next_residue = next_residue + CHARGE_UNITS;
                if (remaining != ZERO_WORD) next_remaining = remaining - HEALTH_STEP;
            end
        end
    end

    // Registers of the estimator.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tick_cnt <= '0;
            current <= '0;
            remaining <= '0;
            residue <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
            current <= next_current;
            remaining <= next_remaining;
            residue <= next_residue;
        end
    end

    assign est.current_ma = current;
    assign est.remaining = remaining;

    level_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
        est.capacity_load |=> remaining == level_capacity($past(est.full_capacity),
                                                          $past(est.energy_level)))
        else $error("remaining charge not loaded from capacity and level");
    charge_step_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !est.capacity_load && !tick |=> remaining == $past(remaining))
        else $error("remaining charge moved between timer ticks");

endmodule : gsr_coulomb

`default_nettype wire

// ---- rtl/gsr_est_if.sv ----
// Signals between the register bank and the current estimator.
`timescale 1ns/1ps
`default_nettype none

interface gsr_est_if;
    logic cell_strobe;
    logic [15:0] cell_mv;
    logic [15:0] ocv_mv;
    logic [15:0] energy_level;
    logic [15:0] full_capacity;
    logic capacity_load;
    logic signed [15:0] current_ma;
    logic [15:0] remaining;

    modport bank (output cell_strobe, output cell_mv, output ocv_mv, output energy_level,
                  output full_capacity, output capacity_load,
                  input current_ma, input remaining);
    modport est (input cell_strobe, input cell_mv, input ocv_mv, input energy_level,
                 input full_capacity, input capacity_load,
                 output current_ma, output remaining);
endinterface : gsr_est_if

`default_nettype wire

// ---- rtl/gsr_pkg.sv ----
// Constants shared by the gauge statistics register bank and its estimator.
`default_nettype none

package gsr_pkg;

    // ------------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PEAK_CHARGE = 8'h2e;
    localparam logic [7:0] ADDR_PEAK_DISCHARGE = 8'h2f;
    localparam logic [7:0] ADDR_AMBIENT_TEMP = 8'h30;
    localparam logic [7:0] ADDR_SHUNT_RES = 8'h31;
    localparam logic [7:0] ADDR_HEALTH = 8'h32;
    localparam logic [7:0] ADDR_INSTANT_UV = 8'h33;
    localparam logic [7:0] ADDR_AVERAGE_UV = 8'h34;
    localparam logic [7:0] ADDR_REMAINING = 8'h35;
    localparam logic [7:0] ADDR_USER_IDENTIFIER_LO = 8'h36;
    localparam logic [7:0] ADDR_USER_IDENTIFIER_HI = 8'h37;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [15:0] PEAK_CHARGE_RESET = 16'h8000;
    localparam logic [15:0] PEAK_DISCHARGE_RESET = 16'h7fff;
    localparam logic [15:0] AMBIENT_MIN = 16'h0980;
    localparam logic [15:0] AMBIENT_MAX = 16'h0dcc;
    localparam logic [15:0] AMBIENT_RESET = 16'h0ba6;
    localparam logic [15:0] SHUNT_MIN = 16'h000a;
    localparam logic [15:0] SHUNT_MAX = 16'h07d0;
    localparam logic [15:0] SHUNT_RESET = 16'h0014;
    localparam logic [15:0] HEALTH_FULL = 16'h0064;
    localparam logic [15:0] HEALTH_STEP = 16'h0001;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam int AVG_SHIFT = 4;

    // ------------------------------------------------------------------
    // Estimator scaling and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] ENERGY_FULL = 16'h03e8;
    localparam int ENERGY_INDEX_SHIFT = 7;
    localparam int MV_PER_MOHM_TO_MA = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int TENTH_MAH_MA_S = 360;
    localparam int CHARGE_UNITS = TENTH_MAH_MA_S * 1000000 / TICK_PERIOD_US;

endpackage : gsr_pkg

`default_nettype wire

// ---- rtl/gsr_stats_regs.sv ----
// Gauge statistics register bank: peaks, temperature, shunt, health, capacity.
//
// Contract
// - Peak charge register keeps highest instant value; host write re-arms from it.
// - Peak discharge register keeps lowest instant value; host write re-arms from it.
// - Ambient temperature in 0.1 K steps, limited to minus 30 to plus 80 C.
// - With ambient sensing enabled, ambient thermistor samples load the ambient register.
// - Ambient temperature never enters any charge-state calculation.
// - Shunt value in 0.1 milliohm steps, one to two hundred milliohms.
// - Health in one-percent steps, starts at 100, only decreases.
// - Instant register holds latest signed shunt microvolts, positive means charging.
// - Average register holds running average of instant value, same format.
// - Remaining charge in 0.1 mAh from full capacity and energy level.
// - User identifier pair returns 32-bit value from non-volatile memory.
// - Current estimate is cell minus open-circuit voltage over table impedance.
// - Charge integrates estimate over timer ticks; remaining charge follows it.
`timescale 1ns/1ps
`default_nettype none

module gsr_stats_regs import gsr_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_shunt_valid,
    input wire logic signed [15:0] i_shunt_uv,
    input wire logic i_ambient_sense_en,
    input wire logic i_ambient_valid,
    input wire logic [15:0] i_ambient_code,
    input wire logic i_cell_valid,
    input wire logic [15:0] i_cell_mv,
    input wire logic [15:0] i_open_circuit_voltage,
    input wire logic [15:0] i_indicated_energy_level,
    input wire logic [15:0] i_full_charge_capacity,
    input wire logic i_capacity_load,
    input wire logic i_health_drop,
    input wire logic [31:0] i_user_identifier,
    output logic signed [15:0] o_estimated_current
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic signed [15:0] peak_charge, next_peak_charge;
    logic signed [15:0] peak_discharge, next_peak_discharge;
    logic [15:0] ambient_temperature, next_ambient_temperature;
    logic [15:0] shunt_resistance, next_shunt_resistance;
    logic [15:0] health_percent, next_health_percent;
    logic signed [15:0] instant_shunt_voltage, next_instant_shunt_voltage;
    logic signed [15:0] average_shunt_voltage, next_average_shunt_voltage;
    logic [15:0] next_reg_rdata;
    logic next_reg_rvalid;
    logic signed [15:0] next_estimated_current;
    logic signed [15:0] charge_base;
    logic signed [15:0] discharge_base;
    logic signed [16:0] avg_delta;

    gsr_est_if est_bus ();

    // True when the host writes the given word address this cycle.
    function automatic logic write_hit(input logic wr, input logic [7:0] addr,
                                       input logic [7:0] target);
        return wr && (addr == target);
    endfunction : write_hit

    // Clamps a value into an inclusive unsigned range.
    function automatic logic [15:0] clamp_range(input logic [15:0] value,
                                                input logic [15:0] low,
                                                input logic [15:0] high);
        logic [15:0] result;
        result = value;
        if (value < low) result = low;
        else if (value > high) result = high;
        return result;
    endfunction : clamp_range

    // ------------------------------------------------------------------
    // Current estimator and coulomb counter
    // ------------------------------------------------------------------

    // The estimator sees cell voltage and energy data only, never the ambient value.
    assign est_bus.cell_strobe = i_cell_valid;
    assign est_bus.cell_mv = i_cell_mv;
    assign est_bus.ocv_mv = i_open_circuit_voltage;
    assign est_bus.energy_level = i_indicated_energy_level;
    assign est_bus.full_capacity = i_full_charge_capacity;
    assign est_bus.capacity_load = i_capacity_load;

    gsr_coulomb #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_coulomb (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .est(est_bus)
    );

    // ------------------------------------------------------------------
    // Peak trackers
    // ------------------------------------------------------------------

    // A host write re-arms the tracker; a measurement in the same cycle is still compared.
    always_comb begin
        charge_base = peak_charge;
        if (write_hit(i_reg_wr, i_reg_addr, ADDR_PEAK_CHARGE)) begin
            charge_base = signed'(i_reg_wdata);
        end
        discharge_base = peak_discharge;
        if (write_hit(i_reg_wr, i_reg_addr, ADDR_PEAK_DISCHARGE)) begin
            discharge_base = signed'(i_reg_wdata);
        end
        next_peak_charge = charge_base;
        if (i_shunt_valid && (i_shunt_uv > charge_base)) begin
            next_peak_charge = i_shunt_uv;
        end
        next_peak_discharge = discharge_base;
        if (i_shunt_valid && (i_shunt_uv < discharge_base)) begin
            next_peak_discharge = i_shunt_uv;
        end
    end

    // ------------------------------------------------------------------
    // Measurements, settings and health
    // ------------------------------------------------------------------

    // Instant and averaged shunt voltage, ambient temperature, shunt setting and health.
    always_comb begin
        next_instant_shunt_voltage = instant_shunt_voltage;
        next_average_shunt_voltage = average_shunt_voltage;
        avg_delta = 17'(i_shunt_uv) - 17'(average_shunt_voltage);
        if (i_shunt_valid) begin
            next_instant_shunt_voltage = i_shunt_uv;
            next_average_shunt_voltage = 16'(17'(average_shunt_voltage)
                                             + (avg_delta >>> AVG_SHIFT));
        end
        next_ambient_temperature = ambient_temperature;
        if (i_ambient_sense_en && i_ambient_valid) begin
            next_ambient_temperature = clamp_range(i_ambient_code, AMBIENT_MIN,
                                                   AMBIENT_MAX);
        end
        next_shunt_resistance = shunt_resistance;
        if (write_hit(i_reg_wr, i_reg_addr, ADDR_SHUNT_RES)) begin
            next_shunt_resistance = clamp_range(i_reg_wdata, SHUNT_MIN, SHUNT_MAX);
        end
        next_health_percent = health_percent;
        if (i_health_drop && (health_percent != ZERO_WORD)) begin
            next_health_percent = health_percent - HEALTH_STEP;
        end
        next_estimated_current = est_bus.current_ma;
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------

    // Read data is answered one cycle after the strobe; unmapped words read as zero.
    always_comb begin
        next_reg_rvalid = i_reg_rd;
        next_reg_rdata = o_reg_rdata;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_PEAK_CHARGE: next_reg_rdata = peak_charge;
                ADDR_PEAK_DISCHARGE: next_reg_rdata = peak_discharge;
                ADDR_AMBIENT_TEMP: next_reg_rdata = ambient_temperature;
                ADDR_SHUNT_RES: next_reg_rdata = shunt_resistance;
                ADDR_HEALTH: next_reg_rdata = health_percent;
                ADDR_INSTANT_UV: next_reg_rdata = instant_shunt_voltage;
                ADDR_AVERAGE_UV: next_reg_rdata = average_shunt_voltage;
                ADDR_REMAINING: next_reg_rdata = est_bus.remaining;
                ADDR_USER_IDENTIFIER_LO: next_reg_rdata = i_user_identifier[15:0];
                ADDR_USER_IDENTIFIER_HI: next_reg_rdata = i_user_identifier[31:16];
                default: next_reg_rdata = ZERO_WORD;
            endcase
        end
    end

    // All bank registers.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            peak_charge <= PEAK_CHARGE_RESET;
            peak_discharge <= PEAK_DISCHARGE_RESET;
            ambient_temperature <= AMBIENT_RESET;
            shunt_resistance <= SHUNT_RESET;
            health_percent <= HEALTH_FULL;
            instant_shunt_voltage <= '0;
            average_shunt_voltage <= '0;
            o_reg_rdata <= ZERO_WORD;
            o_reg_rvalid <= 1'b0;
            o_estimated_current <= '0;
        end else begin
            peak_charge <= next_peak_charge;
            peak_discharge <= next_peak_discharge;
            ambient_temperature <= next_ambient_temperature;
            shunt_resistance <= next_shunt_resistance;
            health_percent <= next_health_percent;
            instant_shunt_voltage <= next_instant_shunt_voltage;
            average_shunt_voltage <= next_average_shunt_voltage;
            o_reg_rdata <= next_reg_rdata;
            o_reg_rvalid <= next_reg_rvalid;
            o_estimated_current <= next_estimated_current;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    peak_charge_up_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_shunt_valid && !i_reg_wr && (i_shunt_uv > peak_charge)
        |=> peak_charge == $past(i_shunt_uv))
        else $error("peak charge missed a larger sample");

    peak_charge_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_reg_wr && i_shunt_valid |=> peak_charge >= $past(i_shunt_uv))
        else $error("peak charge below a measured sample");

    peak_charge_rearm_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == ADDR_PEAK_CHARGE && !i_shunt_valid)
        |=> peak_charge == signed'($past(i_reg_wdata)))
        else $error("peak charge not re-armed by write");

    peak_discharge_down_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_shunt_valid && !i_reg_wr && (i_shunt_uv < peak_discharge)
        |=> peak_discharge == $past(i_shunt_uv))
        else $error("peak discharge missed a smaller sample");

    peak_discharge_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_reg_wr && i_shunt_valid |=> peak_discharge <= $past(i_shunt_uv))
        else $error("peak discharge above a measured sample");

    ambient_range_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ambient_temperature >= AMBIENT_MIN && ambient_temperature <= AMBIENT_MAX)
        else $error("ambient temperature out of range");

    ambient_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !(i_ambient_sense_en && i_ambient_valid) |=> $stable(ambient_temperature))
        else $error("ambient temperature changed while sensing off");

    shunt_range_a: assert property (@(posedge i_clk) disable iff (i_srst)
        shunt_resistance >= SHUNT_MIN && shunt_resistance <= SHUNT_MAX)
        else $error("shunt value out of range");

    health_only_down_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ##1 health_percent <= $past(health_percent) && health_percent <= HEALTH_FULL)
        else $error("health rose or exceeded full");

    health_step_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_health_drop && health_percent != ZERO_WORD
        |=> health_percent == $past(health_percent) - HEALTH_STEP)
        else $error("health did not drop by one step");

    instant_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_shunt_valid |=> instant_shunt_voltage == $past(i_shunt_uv))
        else $error("instant shunt voltage not loaded");

    average_track_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_shunt_valid |=> $stable(average_shunt_voltage))
        else $error("average moved without a sample");

    user_identifier_read_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_reg_rd && i_reg_addr == ADDR_USER_IDENTIFIER_HI
        |=> o_reg_rvalid && o_reg_rdata == $past(i_user_identifier[31:16]))
        else $error("user identifier high word wrong");

    peak_discharge_rearm_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == ADDR_PEAK_DISCHARGE && !i_shunt_valid)
        |=> peak_discharge == signed'($past(i_reg_wdata)))
        else $error("peak discharge not re-armed by write");

    ambient_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ambient_sense_en && i_ambient_valid && i_ambient_code >= AMBIENT_MIN
        && i_ambient_code <= AMBIENT_MAX |=> ambient_temperature == $past(i_ambient_code))
        else $error("ambient sample not loaded");

    shunt_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_reg_wr && i_reg_addr == ADDR_SHUNT_RES && i_reg_wdata >= SHUNT_MIN
        && i_reg_wdata <= SHUNT_MAX |=> shunt_resistance == $past(i_reg_wdata))
        else $error("shunt value write not taken");

    health_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_health_drop |=> $stable(health_percent))
        else $error("health moved without a drop");

    read_valid_a: assert property (@(posedge i_clk) disable iff (i_srst)
        1'b1 |=> o_reg_rvalid == $past(i_reg_rd))
        else $error("read answer not one cycle after strobe");

    read_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");

    remaining_read_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_reg_rd && i_reg_addr == ADDR_REMAINING
        |=> o_reg_rdata == $past(est_bus.remaining))
        else $error("remaining charge read wrong");

endmodule : gsr_stats_regs

`default_nettype wire

// ---- verif/gsr_meas_model.sv ----
// Measurement front-end model that feeds shunt and ambient samples.
`timescale 1ns/1ps
`default_nettype none

module gsr_meas_model (
    input wire logic i_clk,
    output logic o_shunt_valid,
    output logic signed [15:0] o_shunt_uv,
    output logic o_ambient_valid,
    output logic [15:0] o_ambient_code
);
    // Lines start idle with scrambled data.
    initial begin
        o_shunt_valid = 1'b0;
        o_shunt_uv = 16'h5a5a;
        o_ambient_valid = 1'b0;
        o_ambient_code = 16'ha5a5;
    end

    // One shunt conversion; the data is inverted once the pulse ends.
    task automatic shunt(input logic [15:0] v);
        @(posedge i_clk);
        #1;
        o_shunt_uv = v;
        o_shunt_valid = 1'b1;
        @(posedge i_clk);
        #1;
        o_shunt_valid = 1'b0;
        o_shunt_uv = ~v;
    endtask : shunt

    // One ambient thermistor conversion, same shape as the shunt one.
    task automatic ambient(input logic [15:0] v);
        @(posedge i_clk);
        #1;
        o_ambient_code = v;
        o_ambient_valid = 1'b1;
        @(posedge i_clk);
        #1;
        o_ambient_valid = 1'b0;
        o_ambient_code = ~v;
    endtask : ambient
endmodule : gsr_meas_model

`default_nettype wire

// ---- verif/gsr_stats_regs_tb.sv ----
// Self-checking bench for the gauge statistics register bank.
`timescale 1ns/1ps
`default_nettype none

module gsr_stats_regs_tb import gsr_pkg::*;;
    logic clk, srst, wr, rd, rvalid, shv, amen, amv, cellv, capld, hdrop;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, amcode, cellmv, open_circuit_voltage, lvl, fcc;
    logic signed [15:0] shuv, est;
    logic [31:0] uid;
    int err_total = 0;
    int samples_checked = 0;

    gsr_stats_regs #(.TICK_CYCLES(16)) gsr_stats_regs_i (.i_clk(clk), .i_srst(srst),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_shunt_valid(shv), .i_shunt_uv(shuv),
        .i_ambient_sense_en(amen), .i_ambient_valid(amv), .i_ambient_code(amcode),
        .i_cell_valid(cellv), .i_cell_mv(cellmv), .i_open_circuit_voltage(open_circuit_voltage),
        .i_indicated_energy_level(lvl), .i_full_charge_capacity(fcc),
        .i_capacity_load(capld), .i_health_drop(hdrop), .i_user_identifier(uid),
        .o_estimated_current(est));
    gsr_meas_model gsr_meas_model_i (.i_clk(clk), .o_shunt_valid(shv), .o_shunt_uv(shuv),
        .o_ambient_valid(amv), .o_ambient_code(amcode));

    // Clock of 4 ns period.
    always #2 clk = ~clk;

    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Word read: one strobe cycle, answer checked the cycle after.
    task automatic rd_word(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        #1;
        rd = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd = 1'b0;
        chk({15'h0000, rvalid}, 16'h0001);
        chk(rdata, exp);
    endtask : rd_word

    // Word write: one strobe cycle.
    task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr = 1'b0;
        wdata = ~d;
    endtask : wr_word

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // Cuts a hang short.
    initial begin
        #200000;
        err_total++;
        conclude();
    end

    // Main sequence of register accesses and samples.
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        {wr, rd, amen, cellv, capld, hdrop} = 6'h00;
        addr = 8'h00;
        wdata = 16'h0000;
        cellmv = 16'h0e74;
        open_circuit_voltage = 16'h0e74;
        lvl = 16'h03e8;
        fcc = 16'h0500;
        uid = 32'h5a5a_1234;
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        rd_word(ADDR_HEALTH, HEALTH_FULL);
        rd_word(ADDR_SHUNT_RES, SHUNT_RESET);
        rd_word(ADDR_PEAK_CHARGE, PEAK_CHARGE_RESET);
        rd_word(ADDR_PEAK_DISCHARGE, PEAK_DISCHARGE_RESET);
        rd_word(ADDR_USER_IDENTIFIER_LO, 16'h1234);
        rd_word(ADDR_USER_IDENTIFIER_HI, 16'h5a5a);
        rd_word(8'h40, ZERO_WORD);
        gsr_meas_model_i.shunt(16'h0100);
        rd_word(ADDR_INSTANT_UV, 16'h0100);
        rd_word(ADDR_AVERAGE_UV, 16'h0010);
        gsr_meas_model_i.shunt(16'hff00);
        rd_word(ADDR_AVERAGE_UV, 16'hffff);
        rd_word(ADDR_PEAK_CHARGE, 16'h0100);
        rd_word(ADDR_PEAK_DISCHARGE, 16'hff00);
        wr_word(ADDR_PEAK_CHARGE, 16'h0010);
        wr_word(ADDR_PEAK_DISCHARGE, 16'hfff0);
        gsr_meas_model_i.shunt(16'h0050);
        rd_word(ADDR_PEAK_CHARGE, 16'h0050);
        rd_word(ADDR_PEAK_DISCHARGE, 16'hfff0);
        gsr_meas_model_i.shunt(16'hffe0);
        rd_word(ADDR_PEAK_DISCHARGE, 16'hffe0);
        rd_word(ADDR_PEAK_CHARGE, 16'h0050);
        gsr_meas_model_i.ambient(16'h0a00);
        rd_word(ADDR_AMBIENT_TEMP, AMBIENT_RESET);
        amen = 1'b1;
        gsr_meas_model_i.ambient(16'h0a00);
        rd_word(ADDR_AMBIENT_TEMP, 16'h0a00);
        gsr_meas_model_i.ambient(16'h0f00);
        rd_word(ADDR_AMBIENT_TEMP, AMBIENT_MAX);
        gsr_meas_model_i.ambient(16'h0100);
        rd_word(ADDR_AMBIENT_TEMP, AMBIENT_MIN);
        wr_word(ADDR_SHUNT_RES, 16'h0064);
        rd_word(ADDR_SHUNT_RES, 16'h0064);
        wr_word(ADDR_SHUNT_RES, 16'h0900);
        rd_word(ADDR_SHUNT_RES, SHUNT_MAX);
        wr_word(ADDR_HEALTH, 16'h0010);
        hdrop = 1'b1;
        @(posedge clk);
        #1;
        hdrop = 1'b0;
        chk({15'h0000, rvalid}, 16'h0000);
        chk(rdata, SHUNT_MAX);
        rd_word(ADDR_HEALTH, 16'h0063);
        capld = 1'b1;
        @(posedge clk);
        #1;
        capld = 1'b0;
        rd_word(ADDR_REMAINING, 16'h0500);
        cellmv = 16'h0ed8;
        cellv = 1'b1;
        @(posedge clk);
        #1;
        cellv = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(est, 16'h04e2);
        repeat (6000) @(posedge clk);
        rd_word(ADDR_REMAINING, 16'h0501);
        lvl = 16'h01f4;
        fcc = 16'h0c80;
        open_circuit_voltage = 16'h0f3c;
        uid = 32'h0f1e_2d3c;
        {capld, cellv} = 2'h3;
        @(posedge clk);
        #1;
        {capld, cellv} = 2'h0;
        rd_word(ADDR_REMAINING, 16'h0640);
        rd_word(ADDR_USER_IDENTIFIER_HI, 16'h0f1e);
        chk(est, 16'hfcbf);
        conclude();
    end
endmodule : gsr_stats_regs_tb

`default_nettype wire
